// ===== core/bwpm_map.svh
// Register map, command codes and reset values of the write protect manager.
// Assumes a 16-bit word-addressed host register port.
`ifndef BWPM_MAP_SVH
`define BWPM_MAP_SVH

// ----------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------
`define BWPM_ADDR_CMD        16'hF220
`define BWPM_ADDR_TARGET     16'hF24C
`define BWPM_ADDR_STATUS     16'hF24E
`define BWPM_ADDR_FLASH_BLK  16'hF100
`define BWPM_BOOT_END        16'h0200

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define BWPM_CMD_LOCK        16'h002A
`define BWPM_CMD_TIGHT       16'h002C
`define BWPM_CMD_UNLOCK      16'h0023
`define BWPM_CMD_ALL_UNLOCK  16'h0027
`define BWPM_CMD_HOT_RESET   16'h00F3

// ----------------------------------------------------------------------
// Reset values, field sizes and boot load size
// ----------------------------------------------------------------------
`define BWPM_RST_STATUS      16'h0002
`define BWPM_RST_WORD        16'h0000
`define BWPM_STAT_PAD        13'h0000
`define BWPM_SYNC_IDLE       3'h7
`define BWPM_BOOT_WORDS      512
`define BWPM_BOOT_LAST       9'h1FF
`define BWPM_BOOT_CNT_ONE    9'h001
`define BWPM_BOOT_IDX_MSB    8

`endif

// ===== core/bwpm_pkg.sv
// Types shared by the write protect manager.
// Assumes bwpm_map.svh supplies the numeric constants.
package bwpm_pkg;

  // Per-block protection state; the code is also the status bit pattern.
  typedef enum logic [2:0]
  {
    BWPM_UNLOCKED = 3'b100,
    BWPM_LOCKED   = 3'b010,
    BWPM_TIGHT    = 3'b001
  } bwpm_blk_t;

  // Boot loader sequence states.
  typedef enum logic [2:0]
  {
    BWPM_BT_ISSUE = 3'b001,
    BWPM_BT_WAIT  = 3'b010,
    BWPM_BT_DONE  = 3'b100
  } bwpm_boot_t;

  // One host register access.
  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bwpm_hreq_t;

  // One program or erase request from the array sequencer.
  typedef struct packed
  {
    logic        req;
    logic [15:0] blk;
  } bwpm_pereq_t;

endpackage

// ===== core/bwpm_top.sv
// Write protect manager: boot buffer load and lock, per-block flash locks.
// Assumes a host port synchronous to core_clk_in and an array read port.
//
// Notes on behaviour
// - Cold reset copies 1KB bootcode into buffer.
// - Boot buffer is write-locked after loading.
// - Cold or warm reset locks every block.
// - Code 002Ah at F220h locks a block.
// - Lock and lock-tight act on target block.
// - Each block holds unlocked, locked or tight.
// - All-block unlock spares locked-tight blocks.
// - Status shows three flags; hot reset keeps.
// - Status refreshes on block field or command.
// - Status reads 010, 100 or 001.
// - Program or erase only on unlocked blocks.
// - Unlock releases exactly one addressed block.
// - Lock returns an unlocked block to locked.
// - Tight block ignores lock and unlock.
// - Lock-tight only from the locked state.
// - One-time-programmable block 0 stays locked.
// - Status reads 0002h after cold or warm reset.
// - Target block register is read and write.
`include "bwpm_map.svh"

module bwpm_top #(
  parameter int NUM_BLOCKS = 1024
) (
  // Clock and cold reset.
  input  wire logic                 core_clk_in,
  input  wire logic                 rstn_in,
  // Warm reset pin, asynchronous to the core clock.
  input  wire logic                 warm_rstn_in,
  // Host register port.
  input  wire bwpm_pkg::bwpm_hreq_t host_req_in,
  output logic [15:0]               host_rdata_out,
  // Boot fetch from the flash array.
  output logic                      flash_rd_out,
  output logic [15:0]               flash_addr_out,
  input  wire logic [15:0]          flash_rdata_in,
  input  wire logic                 flash_valid_in,
  // Program and erase gate.
  input  wire bwpm_pkg::bwpm_pereq_t pe_req_in,
  output logic                      pe_grant_out,
  output logic                      pe_refuse_out,
  // Configuration and boot state.
  input  wire logic                 otp_block0_in,
  output logic                      boot_done_out
);

  localparam int BAW = $clog2(NUM_BLOCKS);

  if (NUM_BLOCKS < 2 || NUM_BLOCKS > 65536) begin : g_chk
    $error("NUM_BLOCKS must lie between 2 and 65536.");
  end

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  bwpm_pkg::bwpm_blk_t  blk [NUM_BLOCKS];
  logic [15:0]          boot_mem [`BWPM_BOOT_WORDS];
  bwpm_pkg::bwpm_blk_t  status3;
  bwpm_pkg::bwpm_boot_t bt;
  logic [8:0]           bcnt;
  logic [15:0]          cmd_code;
  logic [15:0]          protect_target_block;
  logic [15:0]          fba;
  logic [15:0]          shown;
  logic                 refresh_q;
  logic                 w1;
  logic                 w2;
  logic                 w3;
  logic                 warm_act;

  // True when a block number names an existing block.
  function automatic logic bwpm_in_range(input logic [15:0] b);
    return 32'(b) < NUM_BLOCKS;
  endfunction

  // State of a named block; a block that does not exist reads as locked.
  function automatic bwpm_pkg::bwpm_blk_t bwpm_blk_at(input logic [15:0] b);
    return bwpm_in_range(b) ? blk[b[BAW-1:0]] : bwpm_pkg::BWPM_LOCKED;
  endfunction

  // ----------------------------------------------------------------------
  // Warm reset synchroniser
  // ----------------------------------------------------------------------
  // Three stages; the level is taken once the second and third agree.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      {w3, w2, w1} <= `BWPM_SYNC_IDLE;
    else
      {w3, w2, w1} <= {w2, w1, warm_rstn_in};
  end

  // Warm reset stays active while the filtered pin is low.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      warm_act <= 1'b0;
    else if (w2 == w3)
      warm_act <= ~w2;
  end

  // ----------------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------------
  // A write selects at most one register per cycle.
  wire        h_wr      = host_req_in.wr;
  wire [15:0] h_addr    = host_req_in.addr;
  wire [15:0] h_data    = host_req_in.wdata;
  wire        cmd_wr    = h_wr && (h_addr == `BWPM_ADDR_CMD);
  wire        sba_wr    = h_wr && (h_addr == `BWPM_ADDR_TARGET);
  wire        fba_wr    = h_wr && (h_addr == `BWPM_ADDR_FLASH_BLK);
  wire        op_lock   = cmd_wr && (h_data == `BWPM_CMD_LOCK);
  wire        op_tight  = cmd_wr && (h_data == `BWPM_CMD_TIGHT);
  wire        op_unlock = cmd_wr && (h_data == `BWPM_CMD_UNLOCK);
  wire        op_all    = cmd_wr && (h_data == `BWPM_CMD_ALL_UNLOCK);
  wire        hot_go    = cmd_wr && (h_data == `BWPM_CMD_HOT_RESET);
  wire        op_any    = op_lock || op_tight || op_unlock || op_all;
  wire        sba_ok    = bwpm_in_range(protect_target_block);

  // ----------------------------------------------------------------------
  // Block protection states
  // ----------------------------------------------------------------------
  // Next state of one block for the command in this cycle.
  function automatic bwpm_pkg::bwpm_blk_t bwpm_next(
    input bwpm_pkg::bwpm_blk_t cur,
    input logic                sel,
    input logic                pin0
  );
    bwpm_pkg::bwpm_blk_t nx;
    nx = cur;
    if (cur != bwpm_pkg::BWPM_TIGHT)
    begin
      if (op_all && !pin0)
        nx = bwpm_pkg::BWPM_UNLOCKED;
      if (sel && op_unlock && !pin0)
        nx = bwpm_pkg::BWPM_UNLOCKED;
      if (sel && op_lock)
        nx = bwpm_pkg::BWPM_LOCKED;
      if (sel && op_tight && cur == bwpm_pkg::BWPM_LOCKED)
        nx = bwpm_pkg::BWPM_TIGHT;
    end
    return nx;
  endfunction

  // One state register per block, forced locked by cold or warm reset.
  for (genvar g = 0; g < NUM_BLOCKS; g++) begin : g_blk
    wire sel = sba_ok && (protect_target_block[BAW-1:0] == BAW'(g));
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        blk[g] <= bwpm_pkg::BWPM_LOCKED;
      else if (warm_act)
        blk[g] <= bwpm_pkg::BWPM_LOCKED;
      else
        blk[g] <= bwpm_next(blk[g], sel, otp_block0_in && (g == 0));
    end
  end

  // ----------------------------------------------------------------------
  // Registers and status
  // ----------------------------------------------------------------------
  // Host registers; hot reset clears them but not the status flags.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cmd_code <= `BWPM_RST_WORD;
      protect_target_block      <= `BWPM_RST_WORD;
      fba      <= `BWPM_RST_WORD;
      shown    <= `BWPM_RST_WORD;
    end
    else if (warm_act || hot_go)
    begin
      cmd_code <= `BWPM_RST_WORD;
      protect_target_block      <= `BWPM_RST_WORD;
      fba      <= `BWPM_RST_WORD;
      shown    <= `BWPM_RST_WORD;
    end
    else
    begin
      if (cmd_wr)
        cmd_code <= h_data;
      if (sba_wr)
        protect_target_block <= h_data;
      if (fba_wr)
        fba <= h_data;
      if (op_any)
        shown <= protect_target_block;
      else if (fba_wr)
        shown <= h_data;
    end
  end

  // A refresh is pending in the cycle after the event, once the state it reports has settled.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      refresh_q <= 1'b0;
    else
      refresh_q <= !warm_act && (op_any || fba_wr);
  end

  // Status flags; a hot reset leaves them as they are.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      status3 <= bwpm_pkg::BWPM_LOCKED;
    else if (warm_act)
      status3 <= bwpm_pkg::BWPM_LOCKED;
    else if (refresh_q)
      status3 <= bwpm_blk_at(shown);
  end

  // ----------------------------------------------------------------------
  // Program and erase gate
  // ----------------------------------------------------------------------
  wire pe_ok = bwpm_blk_at(pe_req_in.blk) == bwpm_pkg::BWPM_UNLOCKED;

  // Exactly one of grant or refuse pulses for each request.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pe_grant_out  <= 1'b0;
      pe_refuse_out <= 1'b0;
    end
    else
    begin
      pe_grant_out  <= pe_req_in.req && pe_ok;
      pe_refuse_out <= pe_req_in.req && !pe_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Boot loader
  // ----------------------------------------------------------------------
  // Fetches words 0 onward of the first page of block 0, once per cold reset.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bt             <= bwpm_pkg::BWPM_BT_ISSUE;
      bcnt           <= 9'h000;
      flash_rd_out   <= 1'b0;
      flash_addr_out <= `BWPM_RST_WORD;
    end
    else
    begin
      case (bt)
        bwpm_pkg::BWPM_BT_ISSUE:
        begin
          flash_rd_out   <= 1'b1;
          flash_addr_out <= 16'(bcnt);
          bt             <= bwpm_pkg::BWPM_BT_WAIT;
        end
        bwpm_pkg::BWPM_BT_WAIT:
        begin
          flash_rd_out <= 1'b0;
          if (flash_valid_in)
          begin
            bcnt <= bcnt + `BWPM_BOOT_CNT_ONE;
            bt   <= (bcnt == `BWPM_BOOT_LAST) ? bwpm_pkg::BWPM_BT_DONE
                                              : bwpm_pkg::BWPM_BT_ISSUE;
          end
        end
        bwpm_pkg::BWPM_BT_DONE:
          bt <= bwpm_pkg::BWPM_BT_DONE;
        default:
          bt <= bwpm_pkg::BWPM_BT_ISSUE;
      endcase
    end
  end

  // Only the loader fills the buffer; there is no host write path to it.
  always_ff @(posedge core_clk_in)
  begin
    if (bt == bwpm_pkg::BWPM_BT_WAIT && flash_valid_in)
      boot_mem[bcnt] <= flash_rdata_in;
  end

  // The buffer is offered to the host once the load has completed.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      boot_done_out <= 1'b0;
    else
      boot_done_out <= boot_done_out || (bt == bwpm_pkg::BWPM_BT_DONE);
  end

  // ----------------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------------
  // Writes into the boot range decode to nothing, so the buffer stays locked.
  wire        boot_hit = (h_addr < `BWPM_BOOT_END) && boot_done_out;
  wire [15:0] next_rdata =
    boot_hit                        ? boot_mem[h_addr[`BWPM_BOOT_IDX_MSB:0]] :
    (h_addr == `BWPM_ADDR_CMD)      ? cmd_code :
    (h_addr == `BWPM_ADDR_TARGET)   ? protect_target_block :
    (h_addr == `BWPM_ADDR_FLASH_BLK) ? fba :
    (h_addr == `BWPM_ADDR_STATUS)   ? {`BWPM_STAT_PAD, status3} :
                                      `BWPM_RST_WORD;

  // Read data is captured on the read strobe and held until the next read.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      host_rdata_out <= `BWPM_RST_WORD;
    else if (host_req_in.rd)
      host_rdata_out <= next_rdata;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  wire bwpm_pkg::bwpm_blk_t sba_blk = bwpm_blk_at(protect_target_block);
  wire                      quiet   = !warm_act && sba_ok;

  // A command settles the block, then the status copies it a cycle later.
  sequence s_refresh;
    refresh_q ##1 (status3 == $past(bwpm_blk_at(shown)));
  endsequence

  a_lock_unlocked: assert property (
    op_lock && quiet && sba_blk == bwpm_pkg::BWPM_UNLOCKED
    |=> sba_blk == bwpm_pkg::BWPM_LOCKED)
    else $error("Lock did not lock an unlocked block.");
  a_unlock_one: assert property (
    op_unlock && quiet && protect_target_block != 16'h0000 && sba_blk == bwpm_pkg::BWPM_LOCKED
    |=> sba_blk == bwpm_pkg::BWPM_UNLOCKED && $stable(blk[0]))
    else $error("Unlock did not release exactly the addressed block.");
  a_tight_from_lock: assert property (
    op_tight && quiet && sba_blk == bwpm_pkg::BWPM_UNLOCKED
    |=> sba_blk == bwpm_pkg::BWPM_UNLOCKED)
    else $error("Lock-tight moved an unlocked block.");
  a_tight_holds: assert property (
    (op_lock || op_unlock) && quiet && sba_blk == bwpm_pkg::BWPM_TIGHT
    |=> sba_blk == bwpm_pkg::BWPM_TIGHT)
    else $error("A locked-tight block changed on lock or unlock.");
  a_all_spares_tight: assert property (
    op_all && !warm_act && blk[0] == bwpm_pkg::BWPM_TIGHT
    |=> blk[0] == bwpm_pkg::BWPM_TIGHT)
    else $error("All-block unlock opened a locked-tight block.");
  a_otp_block0: assert property (
    otp_block0_in && (op_unlock || op_all) && !warm_act
    && blk[0] == bwpm_pkg::BWPM_LOCKED |=> blk[0] == bwpm_pkg::BWPM_LOCKED)
    else $error("Block zero was unlocked while one-time-programmable.");
  a_pe_refuse: assert property (
    pe_req_in.req && !pe_ok |=> pe_refuse_out && !pe_grant_out)
    else $error("A program or erase on a protected block was not refused.");
  a_status_refresh: assert property (
    (op_any || fba_wr) && !warm_act |=> s_refresh)
    else $error("Status flags were not refreshed after the event.");
  a_warm_locks: assert property (
    warm_act |=> blk[0] == bwpm_pkg::BWPM_LOCKED
                 && status3 == bwpm_pkg::BWPM_LOCKED)
    else $error("Warm reset did not lock the array.");
  a_hot_keeps: assert property (
    hot_go && !warm_act && !refresh_q |=> $stable(status3))
    else $error("Hot reset disturbed the status flags.");
  a_boot_stays: assert property (
    boot_done_out |=> boot_done_out && bt == bwpm_pkg::BWPM_BT_DONE)
    else $error("Boot buffer left the loaded state.");

endmodule

// ===== verif/bwpm_flash_model.sv
// Flash array stand-in that answers boot word fetches of the manager.
// Assumes single-cycle fetch strobes on the core clock, one fetch outstanding.
module bwpm_flash_model (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Fetch port.
  input  wire logic        rd_in,
  input  wire logic [15:0] addr_in,
  output logic [15:0]      rdata_out,
  output logic             valid_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] held_addr;
  logic [1:0]  wait_cnt;
  logic        busy;

  // Latency follows the low address bits, so prompt and slow answers mix.
  // Outside an answer the data lines toggle, so stale words never look valid.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      busy      <= 1'b0;
      wait_cnt  <= 2'h0;
      held_addr <= 16'h0000;
      valid_out <= 1'b0;
      rdata_out <= 16'hFFFF;
    end
    else if (rd_in)
    begin
      busy      <= 1'b1;
      held_addr <= addr_in;
      wait_cnt  <= addr_in[1:0];
      valid_out <= 1'b0;
      rdata_out <= ~rdata_out;
    end
    else if (busy && wait_cnt == 2'h0)
    begin
      busy      <= 1'b0;
      valid_out <= 1'b1;
      rdata_out <= (held_addr * 16'h0101) ^ 16'h5A3C;
    end
    else
    begin
      wait_cnt  <= wait_cnt - 2'h1;
      valid_out <= 1'b0;
      rdata_out <= ~rdata_out;
    end
  end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench of the write protect manager.
// Assumes the flash model answers boot fetches; the bench plays the host.
`include "bwpm_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int NB = 4;

  logic                  core_clk_in   = 1'b0;
  logic                  rstn_in       = 1'b0;
  logic                  warm_rstn_in  = 1'b1;
  logic                  otp_block0_in = 1'b0;
  bwpm_pkg::bwpm_hreq_t  host_req_in   = '0;
  bwpm_pkg::bwpm_pereq_t pe_req_in     = '0;
  logic [15:0]           host_rdata_out;
  logic [15:0]           flash_addr_out;
  logic [15:0]           flash_rdata_in;
  logic                  flash_rd_out;
  logic                  flash_valid_in;
  logic                  pe_grant_out;
  logic                  pe_refuse_out;
  logic                  boot_done_out;
  int                    err_total = 0;
  int                    compares  = 0;
  bwpm_pkg::bwpm_blk_t   st [NB];
  logic [15:0]           b;
  logic [15:0]           k;
  logic [15:0]           codes [4] = '{`BWPM_CMD_LOCK, `BWPM_CMD_TIGHT, `BWPM_CMD_UNLOCK,
                                       `BWPM_CMD_ALL_UNLOCK};

  // ----------------------------------------------------------------------
  // Design, flash stand-in and clock
  // ----------------------------------------------------------------------
  bwpm_top #(.NUM_BLOCKS(NB)) dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .warm_rstn_in(warm_rstn_in), .host_req_in(host_req_in), .host_rdata_out(host_rdata_out),
    .flash_rd_out(flash_rd_out), .flash_addr_out(flash_addr_out),
    .flash_rdata_in(flash_rdata_in), .flash_valid_in(flash_valid_in),
    .pe_req_in(pe_req_in), .pe_grant_out(pe_grant_out), .pe_refuse_out(pe_refuse_out),
    .otp_block0_in(otp_block0_in), .boot_done_out(boot_done_out));

  bwpm_flash_model flash (.clk_in(core_clk_in), .rstn_in(rstn_in), .rd_in(flash_rd_out),
    .addr_in(flash_addr_out), .rdata_out(flash_rdata_in), .valid_out(flash_valid_in));

  // The clock toggles every half period of 12.5 ns.
  always #12.5 core_clk_in = ~core_clk_in;

  // ----------------------------------------------------------------------
  // Expectation functions and bus tasks
  // ----------------------------------------------------------------------
  // Boot word that the flash stand-in holds at a given index.
  function automatic logic [15:0] bw(input logic [15:0] a);
    return (a * 16'h0101) ^ 16'h5A3C;
  endfunction

  // Status word of a block; blocks beyond the array show locked.
  function automatic logic [15:0] stx(input logic [15:0] a);
    return (a < NB) ? {13'h0000, st[a]} : `BWPM_RST_STATUS;
  endfunction

  // Next protection state of one block under one command.
  function automatic bwpm_pkg::bwpm_blk_t nxt(input bwpm_pkg::bwpm_blk_t c,
                                              input logic [15:0] cmd, input logic keep);
    if (cmd == `BWPM_CMD_LOCK && c == bwpm_pkg::BWPM_UNLOCKED)
      return bwpm_pkg::BWPM_LOCKED;
    if (cmd == `BWPM_CMD_TIGHT && c == bwpm_pkg::BWPM_LOCKED)
      return bwpm_pkg::BWPM_TIGHT;
    if ((cmd == `BWPM_CMD_UNLOCK || cmd == `BWPM_CMD_ALL_UNLOCK) && !keep
        && c == bwpm_pkg::BWPM_LOCKED)
      return bwpm_pkg::BWPM_UNLOCKED;
    return c;
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One host write; the strobe stands for a single cycle.
  task automatic hw(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    host_req_in <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk_in);
    host_req_in <= '0;
  endtask

  // One host read; data is registered at the edge that takes the strobe.
  task automatic rc(input string name, input logic [15:0] a, input logic [15:0] exp);
    @(posedge core_clk_in);
    host_req_in <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk_in);
    host_req_in <= '0;
    #1 chk(name, host_rdata_out, exp);
  endtask

  // One program or erase request; the verdict pulses one cycle later.
  task automatic pe(input logic [15:0] blk, input logic ok);
    @(posedge core_clk_in);
    pe_req_in <= '{1'b1, blk};
    @(posedge core_clk_in);
    pe_req_in <= '0;
    #1 chk("pe_grant", {15'h0000, pe_grant_out}, {15'h0000, ok});
    chk("pe_refuse", {15'h0000, pe_refuse_out}, {15'h0000, !ok});
  endtask

  // Issues one protection command and updates the expected block states.
  task automatic cmd(input logic [15:0] blk, input logic [15:0] c);
    hw(`BWPM_ADDR_TARGET, blk);
    // The block keeps no interrupt status, so the clear step after a command is skipped.
    hw(`BWPM_ADDR_CMD, c);
    for (int j = 0; j < NB; j++)
      if (c == `BWPM_CMD_ALL_UNLOCK || blk == j)
        st[j] = nxt(st[j], c, otp_block0_in && j == 0);
    rc("status_cmd", `BWPM_ADDR_STATUS, stx(blk));
  endtask

  // Prints the verdict and stops the run.
  task automatic end_of_test;
    if (err_total == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  // Cuts a hang short well beyond the boot load and the command traffic.
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    err_total++;
    end_of_test();
  end

  // Reset, boot load, register checks, commands, resets and the one-time block.
  initial
  begin
    void'($urandom(32'h0070));
    repeat (20) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    foreach (st[i]) st[i] = bwpm_pkg::BWPM_LOCKED;
    rc("status_rst", `BWPM_ADDR_STATUS, `BWPM_RST_STATUS);
    rc("boot_early", 16'h0000, 16'h0000);
    for (int i = 0; i <= NB; i++) pe(i[15:0], 1'b0);
    for (int n = 0; n < 6000 && boot_done_out !== 1'b1; n++) @(posedge core_clk_in);
    chk("boot_done", {15'h0000, boot_done_out}, 16'h0001);
    rc("boot_first", 16'h0000, bw(16'h0000));
    rc("boot_last", `BWPM_BOOT_END - 16'h0001, bw(16'h01FF));
    b = 16'($urandom % 512);
    rc("boot_any", b, bw(b));
    hw(b, ~bw(b));
    rc("boot_locked", b, bw(b));
    hw(`BWPM_ADDR_STATUS, 16'h0004);
    rc("status_ro", `BWPM_ADDR_STATUS, `BWPM_RST_STATUS);
    k = 16'($urandom);
    hw(`BWPM_ADDR_TARGET, k);
    rc("target_rw", `BWPM_ADDR_TARGET, k);
    hw(`BWPM_ADDR_CMD, 16'h0055);
    rc("cmd_rw", `BWPM_ADDR_CMD, 16'h0055);
    rc("unmapped", 16'hF300, 16'h0000);
    // Block 1 walks unlock, refused tight, lock, tight, then ignored unlock and lock.
    cmd(16'h0001, `BWPM_CMD_UNLOCK);
    cmd(16'h0001, `BWPM_CMD_TIGHT);
    cmd(16'h0001, `BWPM_CMD_LOCK);
    cmd(16'h0001, `BWPM_CMD_TIGHT);
    cmd(16'h0001, `BWPM_CMD_UNLOCK);
    cmd(16'h0001, `BWPM_CMD_LOCK);
    cmd(16'h0002, `BWPM_CMD_ALL_UNLOCK);
    pe(16'h0001, 1'b0);
    pe(16'h0002, 1'b1);
    for (int i = 0; i < 60; i++)
    begin
      b = 16'($urandom % (NB + 1));
      cmd(b, codes[$urandom % 4]);
      pe(b, b < NB && st[b] == bwpm_pkg::BWPM_UNLOCKED);
    end
    for (int i = 0; i < NB; i++)
    begin
      hw(`BWPM_ADDR_FLASH_BLK, i[15:0]);
      rc("status_blk", `BWPM_ADDR_STATUS, stx(i[15:0]));
    end
    hw(`BWPM_ADDR_CMD, `BWPM_CMD_HOT_RESET);
    rc("status_hot", `BWPM_ADDR_STATUS, stx(NB - 1));
    rc("target_hot", `BWPM_ADDR_TARGET, 16'h0000);
    for (int i = 0; i < NB; i++) pe(i[15:0], st[i] == bwpm_pkg::BWPM_UNLOCKED);
    warm_rstn_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    warm_rstn_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    foreach (st[i]) st[i] = bwpm_pkg::BWPM_LOCKED;
    rc("status_warm", `BWPM_ADDR_STATUS, `BWPM_RST_STATUS);
    for (int i = 0; i < NB; i++) pe(i[15:0], 1'b0);
    rc("boot_warm", 16'h0000, bw(16'h0000));
    otp_block0_in <= 1'b1;
    cmd(16'h0000, `BWPM_CMD_UNLOCK);
    cmd(16'h0000, `BWPM_CMD_ALL_UNLOCK);
    pe(16'h0000, 1'b0);
    pe(16'h0001, 1'b1);
    end_of_test();
  end
endmodule
